// File: rtl/hwls_cfg.svh
// Constants for the half-word and signed-byte load/store block.
`ifndef HWLS_CFG_SVH
`define HWLS_CFG_SVH
`define HWLS_COND_MSB 31
`define HWLS_COND_LSB 28
`define HWLS_BIT_P 24
`define HWLS_BIT_U 23
`define HWLS_BIT_I 22
`define HWLS_BIT_W 21
`define HWLS_BIT_L 20
`define HWLS_RN_MSB 19
`define HWLS_RN_LSB 16
`define HWLS_RD_MSB 15
`define HWLS_RD_LSB 12
`define HWLS_OFFHI_MSB 11
`define HWLS_OFFHI_LSB 8
`define HWLS_BIT_S 6
`define HWLS_BIT_H 5
`define HWLS_OFFLO_MSB 3
`define HWLS_OFFLO_LSB 0
`define HWLS_PC_INDEX 4'hF
`define HWLS_PC_BASE_AHEAD 32'h00000008
`define HWLS_PC_STORE_AHEAD 32'h0000000C
`endif

// File: rtl/hwls_pkg.sv
// Types shared by both ends of the half-word load/store link.
package hwls_pkg;
    // Memory cycle kinds on the link.
    typedef enum logic [1:0] {HWLS_IDLE, HWLS_SEQ, HWLS_NSEQ, HWLS_INT} hwls_cyc_t;
endpackage : hwls_pkg

// File: rtl/hwls_mem_if.sv
// Link between the core's load/store unit and the memory system.
`timescale 1ns/10ps
interface hwls_mem_if;
    hwls_pkg::hwls_cyc_t cycKind;
    logic [31:0] addr;
    logic write;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic fault;
    logic byteOrderSelect;
    modport core (output cycKind, output addr, output write, output wdata,
        input rdata, input fault, input byteOrderSelect);
    modport mem (input cycKind, input addr, input write, input wdata,
        output rdata, output fault, output byteOrderSelect);
endinterface : hwls_mem_if

// File: rtl/hwls_lane_sel.sv
// Lane selection and extension of loaded bytes and half-words.
`timescale 1ns/10ps
module hwls_lane_sel
(
    input wire logic [31:0] busData, // Data bus as returned by memory.
    input wire logic [1:0] addrLow, // Low address bits of the transfer.
    input wire logic byte_order_select, // High for big-endian byte order.
    input wire logic signedLoad, // High for a sign-extending half-word load; byte loads always sign-extend.
    input wire logic halfLoad, // High for a half-word, low for a byte.
    output logic [31:0] result // Extended value for the destination.
);
    // ----------------------------------------------------------
    // Lane picking
    // ----------------------------------------------------------
    // Big-endian flips the lane index so both orders share one shifter.
    wire [1:0] byteLane = byte_order_select ? ~addrLow : addrLow;
    wire halfHigh = byte_order_select ? ~addrLow[1] : addrLow[1];
    wire [7:0] byteVal = busData[{byteLane, 3'h0} +: 8];
    wire [15:0] halfVal = halfHigh ? busData[31:16] : busData[15:0];
    // Address bit 0 is ignored for half-words; the result is then unpredictable anyway.
    assign result = halfLoad ? {{16{signedLoad & halfVal[15]}}, halfVal}
                             : {{24{byteVal[7]}}, byteVal};
endmodule : hwls_lane_sel

// File: rtl/hwls_core_end.sv
// Core end: decode, address forming, lanes and cycle sequencing.
`timescale 1ns/10ps
`include "hwls_cfg.svh"
module hwls_core_end
(
    input wire logic clk, // Core clock, 40 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    hwls_mem_if.core mem, // Memory link.
    input wire logic start, // One-cycle pulse: execute instr.
    input wire logic [31:0] instr, // Instruction word.
    input wire logic [3:0] flags, // Condition flags N Z C V.
    input wire logic [31:0] instrAddr, // Address of this instruction.
    input wire logic [31:0] baseVal, // Contents of base_register.
    input wire logic [31:0] indexVal, // Contents of index_register.
    input wire logic [31:0] srcVal, // Contents of store source register.
    output logic busy, // High while an instruction runs.
    output logic done, // One-cycle pulse at completion.
    output logic baseWrEn, // Pulse: write baseWrData to base.
    output logic [31:0] baseWrData, // Written-back base value.
    output logic destWrEn, // Pulse: write destWrData to dest.
    output logic [3:0] destIdx, // Destination register index.
    output logic [31:0] destWrData, // Loaded, extended value.
    output logic dataFault // Pulse: take the data fault trap.
);
    typedef enum logic [2:0] {ST_IDLE, ST_N1, ST_N2, ST_I, ST_S1, ST_S2} hwls_state_t;
    hwls_state_t state_r, state_nxt;
    logic [31:0] ins_r, addr_r, wb_r, wdata_r, load_r;
    logic wbEn_r, fault_r, done_r;

    // Condition evaluation; flags are N Z C V in bits 3 to 0.
    function automatic logic condPass(input logic [3:0] c, input logic [3:0] f);
        logic r;
        r = 1'b0;
        case (c[3:1])
            3'h0: r = f[2];
            3'h1: r = f[1];
            3'h2: r = f[3];
            3'h3: r = f[0];
            3'h4: r = f[1] & ~f[2];
            3'h5: r = f[3] == f[0];
            3'h6: r = ~f[2] & (f[3] == f[0]);
            default: r = 1'b1;
        endcase
        // Code 14 (always) lands in the default branch with r high and bit 0 low.
        // Code 15 has no meaning here and is refused outright.
        if (c == 4'hF)
            condPass = 1'b0;
        else
            condPass = r ^ c[0];
    endfunction : condPass

    // Register index 15 is the program counter in every register field.
    function automatic logic isPcIdx(input logic [3:0] idx);
        isPcIdx = idx == `HWLS_PC_INDEX;
    endfunction : isPcIdx

    // ----------------------------------------------------------
    // Decode and address forming
    // ----------------------------------------------------------
    wire pBit = instr[`HWLS_BIT_P];
    wire uBit = instr[`HWLS_BIT_U];
    wire wBit = instr[`HWLS_BIT_W];
    wire sBit = instr[`HWLS_BIT_S];
    wire hBit = instr[`HWLS_BIT_H];
    wire [3:0] condField = instr[`HWLS_COND_MSB:`HWLS_COND_LSB];
    wire rnIsPc = isPcIdx(instr[`HWLS_RN_MSB:`HWLS_RN_LSB]);
    wire [31:0] immOff = {24'h0, instr[`HWLS_OFFHI_MSB:`HWLS_OFFHI_LSB],
        instr[`HWLS_OFFLO_MSB:`HWLS_OFFLO_LSB]};
    wire [31:0] offset = instr[`HWLS_BIT_I] ? immOff : indexVal;
    wire [31:0] baseEff = rnIsPc ? instrAddr + `HWLS_PC_BASE_AHEAD : baseVal;
    wire [31:0] modBase = uBit ? baseEff + offset : baseEff - offset;
    wire [31:0] xferAddr = pBit ? modBase : baseEff;
    wire doWb = pBit ? wBit : 1'b1;
    wire rdIsPc = isPcIdx(instr[`HWLS_RD_MSB:`HWLS_RD_LSB]);
    wire [15:0] stHalf = rdIsPc ? 16'(instrAddr + `HWLS_PC_STORE_AHEAD) : srcVal[15:0];
    wire accept = start && state_r == ST_IDLE;
    wire execute = accept && condPass(condField, flags);
    // Only H/S combos that this block owns; S=0,H=0 is another instruction class.
    wire legal = sBit | hBit;
    wire isLoad = ins_r[`HWLS_BIT_L];
    wire loadPc = isPcIdx(ins_r[`HWLS_RD_MSB:`HWLS_RD_LSB]);
    wire [31:0] extVal;

    // Read data and fault come from the memory end's flip-flops on this same clock and
    // byte order straight from its input, so they are used as they stand; two more flip-flops would
    // bring the data in after the internal cycle that takes it, and the fault
    // after a store has already ended.
    wire [31:0] busData = mem.rdata;
    wire memFault = mem.fault;
    // Byte order should only change while idle; a change mid-load picks new lanes.
    wire bigEndian = mem.byteOrderSelect;

    hwls_lane_sel u_lane
    (
        .busData(busData),
        .addrLow(addr_r[1:0]),
        .byte_order_select(bigEndian),
        .signedLoad(ins_r[`HWLS_BIT_S]),
        .halfLoad(ins_r[`HWLS_BIT_H]),
        .result(extVal)
    );

    // ----------------------------------------------------------
    // Cycle sequencing
    // ----------------------------------------------------------
    // Load: N (address) then I (data in, taken as it stands) then S; a PC load adds
    // a refill pair, a second N then one more S. Store: N address, N data.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: state_nxt = (execute && legal) ? ST_N1 : ST_IDLE;
            ST_N1: state_nxt = isLoad ? ST_I : ST_N2;
            ST_N2: state_nxt = (isLoad && loadPc) ? ST_S2 : ST_IDLE;
            ST_I: state_nxt = ST_S1;
            ST_S1: state_nxt = (loadPc && !fault_r) ? ST_N2 : ST_IDLE;
            ST_S2: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Fault is collected during the data phase and masks the destination write.
    // A fault seen before S1 of a counter load drops the refill pair as well.
    wire faultNow = memFault && state_r != ST_IDLE;
    wire lastCyc = state_r != ST_IDLE && state_nxt == ST_IDLE;
    wire loadDone = state_r == ST_S1;

    // Instruction capture, state, completion pulse and the fault flag.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= ST_IDLE;
            ins_r <= 32'h0;
            addr_r <= 32'h0;
            wb_r <= 32'h0;
            wdata_r <= 32'h0;
            load_r <= 32'h0;
            wbEn_r <= 1'b0;
            fault_r <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            done_r <= lastCyc || (accept && !(execute && legal));
            if (execute && legal)
            begin
                ins_r <= instr;
                addr_r <= xferAddr;
                wb_r <= modBase;
                wbEn_r <= doWb;
                fault_r <= 1'b0;
                wdata_r <= {stHalf, stHalf};
            end
            else if (faultNow)
                fault_r <= 1'b1;
            if (state_r == ST_I)
                load_r <= extVal;
        end
    end

    // ----------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------
    // State groups that name the memory cycle kind.
    wire inNonSeq = state_r == ST_N1 || state_r == ST_N2;
    wire inSeq = state_r == ST_S1 || state_r == ST_S2;
    assign mem.cycKind = inNonSeq ? hwls_pkg::HWLS_NSEQ :
        (state_r == ST_I) ? hwls_pkg::HWLS_INT :
        inSeq ? hwls_pkg::HWLS_SEQ : hwls_pkg::HWLS_IDLE;
    // Address and store data stand from N1 until the next instruction that executes.
    assign mem.addr = addr_r;
    assign mem.write = !isLoad && state_r == ST_N1;
    assign mem.wdata = wdata_r;
    // Core-side status and register file strobes.
    assign busy = state_r != ST_IDLE;
    assign done = done_r;
    // Base write-back is kept even on a fault so the handler can unwind it.
    assign baseWrEn = state_r == ST_N1 && wbEn_r;
    assign baseWrData = wb_r;
    assign destWrEn = loadDone && isLoad && !fault_r && !faultNow;
    assign destIdx = ins_r[`HWLS_RD_MSB:`HWLS_RD_LSB];
    assign destWrData = load_r;
    assign dataFault = lastCyc && (fault_r || faultNow);
endmodule : hwls_core_end

// File: rtl/hwls_mem_end.sv
// Memory end: array with half-word lane writes and a fault request.
`timescale 1ns/10ps
module hwls_mem_end
#(
    parameter int ADDR_W = 8 // Word address width of the array.
)
(
    input wire logic clk, // Core clock.
    input wire logic rst, // Asynchronous reset, active high.
    hwls_mem_if.mem mem, // Memory link.
    input wire logic byte_order_select, // Byte order to present to the core.
    input wire logic faultReq, // Level: fault every access now.
    output logic [31:0] lastWrite // Word last written to the array.
);
    logic [31:0] ram [0:(1 << ADDR_W) - 1];
    logic [31:0] rdata_r, last_r;
    logic fault_r;
    wire [ADDR_W-1:0] wIdx = mem.addr[ADDR_W+1:2];
    // Half-word lane chosen by address and byte order.
    wire hiHalf = byte_order_select ? ~mem.addr[1] : mem.addr[1];
    wire active = mem.cycKind == hwls_pkg::HWLS_NSEQ;
    // The word as it stands in the array once the addressed half is written.
    wire [31:0] mergedWord = hiHalf ? {mem.wdata[31:16], ram[wIdx][15:0]}
                                    : {ram[wIdx][31:16], mem.wdata[15:0]};

    // Only the addressed half of the replicated store word is written.
    always_ff @(posedge clk)
    begin
        if (active && mem.write && !faultReq)
        begin
            if (hiHalf)
                ram[wIdx][31:16] <= mem.wdata[31:16];
            else
                ram[wIdx][15:0] <= mem.wdata[15:0];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_r <= 32'h0;
            fault_r <= 1'b0;
            last_r <= 32'h0;
        end
        else
        begin
            if (active)
                rdata_r <= ram[wIdx];
            fault_r <= faultReq && mem.cycKind != hwls_pkg::HWLS_IDLE;
            if (active && mem.write && !faultReq)
                last_r <= mergedWord;
        end
    end

    assign mem.rdata = rdata_r;
    assign mem.fault = fault_r;
    assign mem.byteOrderSelect = byte_order_select;
    assign lastWrite = last_r;
endmodule : hwls_mem_end

// File: verification/hwls_props.sv
// Concurrent checks on the link between the two ends.
`timescale 1ns/10ps
module hwls_props
(
    input wire logic clk, // Core clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire hwls_pkg::hwls_cyc_t cycKind, // Memory cycle kind.
    input wire logic [31:0] addr, // Transfer address.
    input wire logic write, // Write strobe.
    input wire logic [31:0] wdata // Store data.
);
    // Short names keep the properties readable.
    localparam hwls_pkg::hwls_cyc_t ID = hwls_pkg::HWLS_IDLE;
    localparam hwls_pkg::hwls_cyc_t NS = hwls_pkg::HWLS_NSEQ;
    localparam hwls_pkg::hwls_cyc_t IN = hwls_pkg::HWLS_INT;
    localparam hwls_pkg::hwls_cyc_t SQ = hwls_pkg::HWLS_SEQ;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Stores and their cycle pattern.
    store_repl_a: assert property (
        write && cycKind == NS |-> wdata[31:16] == wdata[15:0])
        else $error("store data not replicated");
    store_two_n_a: assert property (
        write && cycKind == NS && $past(cycKind) != NS |=> cycKind == NS)
        else $error("store lacks second non-sequential cycle");
    store_hold_a: assert property (
        write && cycKind == NS |=> $stable(wdata))
        else $error("store data moved");
    // Loads: one non-sequential, one internal, then sequential.
    load_order_a: assert property (
        !write && cycKind == NS && $past(cycKind) == ID |=> cycKind == IN ##1 cycKind == SQ)
        else $error("load cycle order wrong");
    int_cause_a: assert property (
        cycKind == IN |-> $past(cycKind) == NS && $stable(addr) && !write)
        else $error("internal cycle out of place");
    seq_cause_a: assert property (
        cycKind == SQ |-> $past(cycKind) == IN || $past(cycKind) == NS)
        else $error("sequential cycle out of place");
    pc_tail_a: assert property (
        cycKind == NS && $past(cycKind) == SQ |=> cycKind == SQ ##1 cycKind != SQ)
        else $error("counter load tail wrong");
    no_write_a: assert property (
        cycKind == IN || cycKind == SQ |-> !write)
        else $error("write during load cycles");
endmodule : hwls_props

// File: verification/halfword_signed_load_store_tb_top.sv
// Self-checking bench joining core end and memory end.
`timescale 1ns/10ps
module halfword_signed_load_store_tb_top;
    logic clk = 0, rst = 1, start = 0, byte_order_select = 0, faultReq = 0;
    logic [31:0] instr = 0, instrAddr = 0, baseVal = 0, indexVal = 0, srcVal = 0;
    logic [3:0] flags = 0, destIdx;
    logic busy, done, baseWrEn, destWrEn, dataFault;
    logic [31:0] baseWrData, destWrData, lastWrite, rnd = 32'h73AF5F18;
    logic [31:0] mdl [0:3];
    int mismatches = 0, testsRun = 0;
    // Both ends meet on one link; the checker watches it.
    hwls_mem_if hwls_mem_if_inst ();
    hwls_core_end hwls_core_end_inst (.clk(clk), .rst(rst), .mem(hwls_mem_if_inst.core),
        .start(start), .instr(instr), .flags(flags), .instrAddr(instrAddr), .baseVal(baseVal),
        .indexVal(indexVal), .srcVal(srcVal), .busy(busy), .done(done), .baseWrEn(baseWrEn),
        .baseWrData(baseWrData), .destWrEn(destWrEn), .destIdx(destIdx),
        .destWrData(destWrData), .dataFault(dataFault));
    hwls_mem_end #(.ADDR_W(8)) hwls_mem_end_inst (.clk(clk), .rst(rst),
        .mem(hwls_mem_if_inst.mem), .byte_order_select(byte_order_select), .faultReq(faultReq), .lastWrite(lastWrite));
    hwls_props hwls_props_inst (.clk(clk), .rst(rst), .cycKind(hwls_mem_if_inst.cycKind),
        .addr(hwls_mem_if_inst.addr), .write(hwls_mem_if_inst.write),
        .wdata(hwls_mem_if_inst.wdata));
    // Free-running 40 MHz clock.
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    function automatic logic [31:0] lfsrNext(input logic [31:0] v);
        lfsrNext = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsrNext
    task automatic checkVal(input logic [31:0] got, input logic [31:0] exp, input string what);
        testsRun++;
        if (got !== exp)
        begin
            mismatches++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : checkVal
    task automatic stop_test();
        $display("Counts: %0d checks, %0d mismatches", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    // One instruction: m is {pcBase,P,U,I,W,L,S,H}; the model word array is updated too.
    task automatic op(input logic [3:0] cond, input logic [7:0] m, input logic [3:0] rd,
        input logic [31:0] ta, input logic [3:0] f);
        logic [7:0] off;
        logic [31:0] be, md, w, v, ld, gA, gW, gB, gD;
        logic ok, act, wb, hi, gBe, gDe, gF, gBsy;
        int cyc, ln;
        rnd = lfsrNext(rnd);
        off = rnd[7:0];
        be = !m[6] ? ta : (m[5] ? ta - off : ta + off);
        md = m[6] ? ta : (m[5] ? ta + off : ta - off);
        instrAddr = m[7] ? be - 32'h8 : {rnd[15:0], rnd[31:16]};
        baseVal = m[7] ? ~rnd : be;
        indexVal = m[4] ? ~rnd : {24'h0, off};
        srcVal = rnd;
        instr = {cond, 3'b000, m[6:2], m[7] ? 4'hF : 4'h3, rd, off[7:4], 1'b1, m[1:0], 1'b1,
            off[3:0]};
        flags = f;
        start = 1;
        ok = cond == 4'hE || (cond == 4'h0 && f[2]) || (cond == 4'h1 && !f[2]);
        act = ok && (m[1] || m[0]);
        wb = act && (!m[6] || m[3]);
        hi = byte_order_select ? !ta[1] : ta[1];
        v = (rd == 4'hF) ? instrAddr + 32'hC : srcVal;
        w = mdl[ta[3:2]];
        if (act && !m[2])
        begin
            if (hi) w[31:16] = v[15:0]; else w[15:0] = v[15:0];
            mdl[ta[3:2]] = w;
        end
        ln = byte_order_select ? 3 - ta[1:0] : ta[1:0];
        ld = m[0] ? {{16{m[1] & (hi ? w[31] : w[15])}}, hi ? w[31:16] : w[15:0]}
            : {{24{w[8 * ln + 7]}}, w[8 * ln +: 8]};
        {cyc, gBe, gDe, gF, gB, gD} = 0;
        do
        begin
            @(negedge clk);
            start = 0;
            cyc++;
            if (cyc == 1)
                {gA, gW, gBsy} = {hwls_mem_if_inst.addr, hwls_mem_if_inst.wdata, busy};
            if (baseWrEn) {gBe, gB} = {1'b1, baseWrData};
            if (destWrEn) {gDe, gD} = {1'b1, destWrData};
            gF |= dataFault;
        end while (done !== 1'b1 && cyc < 20);
        checkVal(cyc, !act ? 1 : (!m[2] ? 3 : (rd == 4'hF ? 6 : 4)), "cycles");
        checkVal(gBe, wb, "base write");
        if (wb) checkVal(gB, md, "base value");
        checkVal(gF, act & faultReq, "fault");
        checkVal(gDe, act & m[2] & !faultReq, "dest write");
        if (act) checkVal(gA, ta, "address");
        if (act && !m[2]) checkVal(gW, {v[15:0], v[15:0]}, "store data");
        if (gDe) checkVal(gD, ld, "load data");
        if (gDe) checkVal(destIdx, rd, "dest index");
        checkVal(gBsy, act, "busy");
    endtask : op
    // Main sequence: fill, random loads, conditions, counter cases, fault, per byte order.
    initial
    begin
        logic [7:0] mm;
        repeat (3) @(posedge clk);
        @(negedge clk) rst = 0;
        for (int e = 0; e < 2; e++)
        begin
            byte_order_select = e[0];
            repeat (5) @(negedge clk);
            for (int k = 0; k < 8; k++)
            begin
                op(4'hE, k[0] ? 8'h79 : 8'h71, 4'h2, 32'h100 + 2 * k, 4'h0);
                if (k[0]) checkVal(lastWrite, mdl[k / 2], "array word");
            end
            for (int k = 0; k < 24; k++)
            begin
                rnd = lfsrNext(rnd);
                mm = {1'b0, rnd[6:4], rnd[6] & rnd[3], 1'b1, rnd[2:1]};
                op(4'hE, mm, {1'b0, rnd[10:8]}, {28'h0000010, rnd[19:17], rnd[16] & ~mm[0]},
                    4'h0);
            end
            for (int c = 0; c < 6; c++)
                op(c < 2 ? 4'h0 : (c < 4 ? 4'h1 : 4'hE), 8'h77, 4'h5, 32'h104,
                    {1'b0, c[0], 2'b00});
            op(4'hE, 8'hF1, 4'hF, 32'h10A, 4'h0);
            op(4'hE, 8'h75, 4'hF, 32'h10A, 4'h0);
            faultReq = 1;
            op(4'hE, 8'h26, 4'h1, 32'h103, 4'h0);
            faultReq = 0;
            repeat (4) @(negedge clk);
            $display("Byte order %0d pass done", e);
        end
        stop_test();
    end
    // Watchdog: the whole run needs well under 1000 cycles.
    initial
    begin
        #75000;
        mismatches++;
        $display("FAIL %0t run did not finish", $time);
        stop_test();
    end
endmodule : halfword_signed_load_store_tb_top
